/* File: logic/mst_pkg.sv */
// Purpose: Shared constants and types for the writable microstore with load path and trap vectoring.
// Assumes: One 50 MHz system clock, synchronous active-high reset.
// Notes: Byte offsets are APB byte addresses; every register is one aligned 32-bit word.
package mst_pkg;

  localparam int MST_AW = 14;
  localparam int MST_IW = 13;
  localparam int MST_WORDS = 8192;
  localparam int MST_BYTES = 7;
  localparam int MST_MW = 48;
  localparam int MST_SW = 56;
  localparam int MST_PAR_LSB = 48;
  localparam int MST_PAR_SPLIT = 24;
  localparam int MST_ALIGN_LSB = 27;

  localparam logic [7:0] MST_OFF_CTRL = 8'h00;
  localparam logic [7:0] MST_OFF_PDATA = 8'h04;
  localparam logic [7:0] MST_OFF_PADDR = 8'h08;
  localparam logic [7:0] MST_OFF_CMD = 8'h0C;
  localparam logic [7:0] MST_OFF_STAT = 8'h10;
  localparam logic [7:0] MST_OFF_TRAP = 8'h14;
  localparam logic [7:0] MST_OFF_RBYTE = 8'h18;
  localparam logic [7:0] MST_OFF_CADDR = 8'h1C;

  localparam int MST_CTRL_RUN = 0;
  localparam int MST_CMD_WR = 0;
  localparam int MST_CMD_RD = 1;
  localparam int MST_STAT_CNT = 0;
  localparam int MST_STAT_PEND = 3;
  localparam int MST_STAT_RUN = 4;
  localparam int MST_STAT_IDLE = 5;
  localparam logic MST_RUN_RST = 1'b0;

  localparam logic [2:0] MST_RALIGN_A = 3'h1;
  localparam logic [2:0] MST_RALIGN_B = 3'h2;

  localparam int MST_NTRAP = 21;
  localparam int T_POWER = 0;
  localparam int T_INIT = 1;
  localparam int T_BADPA = 2;
  localparam int T_TR0 = 3;
  localparam int T_TR12 = 4;
  localparam int T_PROT = 5;
  localparam int T_RALA = 6;
  localparam int T_RALB = 7;
  localparam int T_WAL = 8;
  localparam int T_HAL = 9;
  localparam int T_OVF = 10;
  localparam int T_MMP = 11;
  localparam int T_EXE = 12;
  localparam int T_SPAR = 13;
  localparam int T_EXT = 14;
  localparam int T_DBG = 15;
  localparam int T_CLKM = 16;
  localparam int T_CLKI = 17;
  localparam int T_IO = 18;
  localparam int T_PAGE = 19;
  localparam int T_ENTRY = 20;

  // Index order equals vector order, so lowest index is served first
  localparam logic [13:0] MST_TRAP_VEC [MST_NTRAP] = '{
    14'h0000, 14'h0001, 14'h0002, 14'h0003, 14'h0004, 14'h0005, 14'h0006,
    14'h0007, 14'h0008, 14'h0009, 14'h000A, 14'h000B, 14'h000C, 14'h000D,
    14'h0011, 14'h0012, 14'h0013, 14'h0014, 14'h0015, 14'h0016, 14'h0017
  };
  localparam logic [MST_NTRAP-1:0] MST_TRAP_RST = 21'h000001;

  typedef struct packed {
    logic init;
    logic bad_physical_address_trap;
    logic translate_reg0_trap;
    logic translate_reg12_trap;
    logic protection_trap;
    logic read_align;
    logic write_align_trap;
    logic halfword_align_trap;
    logic counter_overflow;
    logic add_to_counter_op;
    logic subtract_from_counter_op;
    logic main_mem_parity_trap;
    logic execute_target_trap;
    logic external_event_trap;
    logic software_breakpoint_trap;
    logic clock_maint_trap;
    logic clock_int;
    logic io_int;
    logic io_interrupt_allow;
    logic page_break_trap;
    logic entry_page_break_trap;
    logic next_macro;
  } mst_trap_in_s;

  typedef struct packed {
    logic valid;
    logic [7:0] loader_byte_in;
    logic [13:0] loader_store_address;
  } mst_load_s;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DISPATCH,
    ST_READ,
    ST_EXEC,
    ST_WRITE,
    ST_RDWAIT,
    ST_RDDONE
  } mst_state_e;

endpackage

/* File: logic/mst_store.sv */
// Purpose: Microstore array, 8K words of seven byte lanes, byte-wise write.
// Assumes: Write enables and address arrive from registers.
// Notes: Read data is registered; the top lane keeps only two parity bits of use.
`timescale 1ns/1ps
module mst_store
  import mst_pkg::*;
(
  input wire logic clk_i,
  input wire logic [MST_BYTES-1:0] we_i,
  input wire logic [MST_IW-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [MST_SW-1:0] rdata_o
);

  logic [MST_SW-1:0] mem [MST_WORDS];

  always_ff @(posedge clk_i) begin
    for (int i = 0; i < MST_BYTES; i++) begin
      if (we_i[i]) begin
        mem[addr_i][i*8 +: 8] <= wdata_i;
      end
    end
    rdata_o <= mem[addr_i];
  end

endmodule

/* File: logic/mst_core.sv */
// Purpose: Microstore load path, sequential fetch and trap vectoring behind an APB slave.
// Assumes: Trap inputs are one-cycle pulses synchronous to clk_i; branch inputs valid in dispatch.
// Notes: One microinstruction takes three clocks: dispatch, array read, output load.
`timescale 1ns/1ps

// Summary of operation
// RULE_01 - Store holds 8K words of 50 bits: 48 instruction plus 2 parity.
// RULE_02 - Store addresses are 14 bits; only the lower 8K are populated.
// RULE_03 - Word is six instruction bytes plus a seventh byte holding parity.
// RULE_04 - Read-store and write-store commands move exactly one byte each.
// RULE_05 - Loader byte and 14-bit address are written through the data buffer.
// RULE_06 - Byte counter steps seven write enables and wraps after the last.
// RULE_07 - Patch writes take byte and address from software registers, counted.
// RULE_08 - System load raises a trap that branches to location zero.
// RULE_09 - Trap vector goes to the address latch; counter loads vector plus one.
// RULE_10 - All byte write enables stay inactive during fetch.
// RULE_11 - Output register always drives all 48 instruction bits.
// RULE_12 - Counter steps sequentially unless branch, trap or store write intervenes.
// RULE_13 - Vectors 0000 to 0005 for power, initialize and address traps.
// RULE_14 - Alignment traps vector 0006 to 0009, read case by bits 27-29.
// RULE_15 - Overflow on add or subtract counter to 000A, parity 000B, execute 000C.
// RULE_16 - Store parity error traps to 000D.
// RULE_17 - Next-macro traps vector 0011 to 0017; IO only when allowed.
// RULE_18 - Traps are captured in a latch, then prioritised to one vector.
// RULE_19 - All vectors point into the writable store.
// RULE_20 - Lowest latched vector served first; others stay pending.
// RULE_21 - Fetched words are parity checked; mismatch raises store parity trap.
// RULE_22 - Reset clears counter and latch and forces the power-on vector first.
module mst_core
  import mst_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire mst_load_s loader_i,
  input wire mst_trap_in_s trap_i,
  input wire logic sys_load_i,
  input wire logic branch_i,
  input wire logic [MST_AW-1:0] branch_addr_i,
  output logic [MST_MW-1:0] microword_o,
  output logic word_valid_o,
  output logic [MST_AW-1:0] store_addr_o,
  output logic [MST_BYTES-1:0] byte_write_strobes_o,
  output logic trap_taken_o,
  output logic loader_ready_o
);

  mst_state_e state_r, state_nxt;
  logic [MST_AW-1:0] ic_r, ic_nxt;
  logic [MST_AW-1:0] addr_r, addr_nxt;
  logic [7:0] wdata_r, wdata_nxt;
  logic [MST_BYTES-1:0] strb_r, strb_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic [MST_MW-1:0] mw_r, mw_nxt;
  logic [MST_NTRAP-1:0] trap_r, trap_nxt;
  logic op_pend_r, op_pend_nxt;
  logic op_rd_r, op_rd_nxt;
  logic [MST_AW-1:0] op_addr_r, op_addr_nxt;
  logic [7:0] op_data_r, op_data_nxt;
  logic [7:0] rbyte_r, rbyte_nxt;
  logic word_valid_r, word_valid_nxt;
  logic taken_r, taken_nxt;
  logic rdy_r, rdy_nxt;

  logic run_r, run_nxt;
  logic [7:0] patch_byte_in_r, patch_byte_in_nxt;
  logic [MST_AW-1:0] patch_store_address_r, patch_store_address_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;

  logic [MST_SW-1:0] rdata;
  logic [MST_NTRAP-1:0] trap_set;
  logic [MST_NTRAP-1:0] trap_clr;
  logic trap_any;
  logic [4:0] trap_idx;
  logic [2:0] align_sel;
  logic par_bad;
  logic cmd_wr_go;
  logic cmd_rd_go;
  logic apb_done;
  logic apb_first;
  logic mapped;

  mst_store u_store ( // RULE_01
    .clk_i(clk_i),
    .we_i(strb_r),
    .addr_i(addr_r[MST_IW-1:0]),
    .wdata_i(wdata_r),
    .rdata_o(rdata)
  );

  // Alignment case taken from the word currently being executed
  assign align_sel = {mw_r[MST_ALIGN_LSB], mw_r[MST_ALIGN_LSB+1], mw_r[MST_ALIGN_LSB+2]};
  assign par_bad = (rdata[MST_PAR_LSB] != ^rdata[MST_PAR_SPLIT-1:0]) |
                   (rdata[MST_PAR_LSB+1] != ^rdata[MST_MW-1:MST_PAR_SPLIT]); // RULE_21

  always_comb begin
    trap_set = '0;
    trap_set[T_POWER] = sys_load_i; // RULE_08
    trap_set[T_INIT] = trap_i.init; // RULE_13
    trap_set[T_BADPA] = trap_i.bad_physical_address_trap;
    trap_set[T_TR0] = trap_i.translate_reg0_trap;
    trap_set[T_TR12] = trap_i.translate_reg12_trap;
    trap_set[T_PROT] = trap_i.protection_trap;
    trap_set[T_RALA] = trap_i.read_align && (align_sel == MST_RALIGN_A); // RULE_14
    trap_set[T_RALB] = trap_i.read_align && (align_sel == MST_RALIGN_B); // RULE_14
    trap_set[T_WAL] = trap_i.write_align_trap;
    trap_set[T_HAL] = trap_i.halfword_align_trap;
    trap_set[T_OVF] = trap_i.counter_overflow &
                      (trap_i.add_to_counter_op | trap_i.subtract_from_counter_op); // RULE_15
    trap_set[T_MMP] = trap_i.main_mem_parity_trap; // RULE_15
    trap_set[T_EXE] = trap_i.execute_target_trap & trap_i.next_macro; // RULE_15
    trap_set[T_SPAR] = (state_r == ST_EXEC) && par_bad; // RULE_16
    trap_set[T_EXT] = trap_i.external_event_trap & trap_i.next_macro; // RULE_17
    trap_set[T_DBG] = trap_i.software_breakpoint_trap & trap_i.next_macro;
    trap_set[T_CLKM] = trap_i.clock_maint_trap & trap_i.next_macro;
    trap_set[T_CLKI] = trap_i.clock_int & trap_i.next_macro;
    trap_set[T_IO] = trap_i.io_int & trap_i.io_interrupt_allow & trap_i.next_macro; // RULE_17
    trap_set[T_PAGE] = trap_i.page_break_trap & trap_i.next_macro;
    trap_set[T_ENTRY] = trap_i.entry_page_break_trap & trap_i.next_macro;
  end

  // Lowest index wins; the scan runs downward so the last hit is the lowest
  always_comb begin
    trap_any = |trap_r;
    trap_idx = 5'h00;
    for (int i = MST_NTRAP - 1; i >= 0; i--) begin
      if (trap_r[i]) begin
        trap_idx = 5'(i); // RULE_20
      end
    end
  end

  always_comb begin
    state_nxt = state_r;
    ic_nxt = ic_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    strb_nxt = '0; // RULE_10
    cnt_nxt = cnt_r;
    mw_nxt = mw_r;
    op_pend_nxt = op_pend_r;
    op_rd_nxt = op_rd_r;
    op_addr_nxt = op_addr_r;
    op_data_nxt = op_data_r;
    rbyte_nxt = rbyte_r;
    word_valid_nxt = 1'b0;
    taken_nxt = 1'b0;
    trap_clr = '0;
    // Loader has priority over a patch command in the same cycle
    if (loader_i.valid && !op_pend_r) begin
      op_pend_nxt = 1'b1; // RULE_05
      op_rd_nxt = 1'b0;
      op_addr_nxt = loader_i.loader_store_address;
      op_data_nxt = loader_i.loader_byte_in;
    end else if ((cmd_wr_go || cmd_rd_go) && !op_pend_r) begin
      op_pend_nxt = 1'b1; // RULE_07
      op_rd_nxt = cmd_rd_go && !cmd_wr_go;
      op_addr_nxt = patch_store_address_r;
      op_data_nxt = patch_byte_in_r;
    end
    case (state_r)
      ST_IDLE: begin
        if (!op_pend_r && run_r) begin
          state_nxt = ST_DISPATCH;
        end
      end
      ST_DISPATCH: begin
        if (trap_any) begin
          addr_nxt = MST_TRAP_VEC[trap_idx]; // RULE_09 RULE_18 RULE_19
          trap_clr[trap_idx] = 1'b1;
          taken_nxt = 1'b1;
        end else if (branch_i) begin
          addr_nxt = branch_addr_i;
        end else begin
          addr_nxt = ic_r; // RULE_12
        end
        ic_nxt = addr_nxt + 14'h0001; // RULE_09
        state_nxt = ST_READ;
      end
      ST_READ: begin
        state_nxt = ST_EXEC;
      end
      ST_EXEC: begin
        mw_nxt = rdata[MST_MW-1:0]; // RULE_11
        word_valid_nxt = 1'b1;
        state_nxt = run_r ? ST_DISPATCH : ST_IDLE;
      end
      ST_WRITE: begin
        state_nxt = ST_IDLE;
      end
      ST_RDWAIT: begin
        state_nxt = ST_RDDONE;
      end
      ST_RDDONE: begin
        rbyte_nxt = rdata[{cnt_r, 3'b000} +: 8]; // RULE_04
        cnt_nxt = (cnt_r == 3'(MST_BYTES - 1)) ? 3'h0 : cnt_r + 3'h1;
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    // A pending store access interrupts sequencing at a word boundary
    if (op_pend_r && (state_r == ST_IDLE || state_r == ST_EXEC)) begin
      op_pend_nxt = 1'b0;
      addr_nxt = op_addr_r;
      if (op_rd_r) begin
        state_nxt = ST_RDWAIT;
      end else begin
        wdata_nxt = op_data_r; // RULE_03
        // Upper 8K is not populated, so the write is dropped but still counted
        strb_nxt = op_addr_r[MST_AW-1] ? '0 : 7'(7'h01 << cnt_r); // RULE_02 RULE_06
        cnt_nxt = (cnt_r == 3'(MST_BYTES - 1)) ? 3'h0 : cnt_r + 3'h1; // RULE_06
        state_nxt = ST_WRITE;
      end
    end
    trap_nxt = (trap_r & ~trap_clr) | trap_set; // RULE_18
    rdy_nxt = !op_pend_nxt;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_r <= ST_IDLE;
      ic_r <= '0;
      addr_r <= '0;
      wdata_r <= '0;
      strb_r <= '0;
      cnt_r <= '0; // RULE_22
      mw_r <= '0;
      trap_r <= MST_TRAP_RST; // RULE_22
      op_pend_r <= 1'b0;
      op_rd_r <= 1'b0;
      op_addr_r <= '0;
      op_data_r <= '0;
      rbyte_r <= '0;
      word_valid_r <= 1'b0;
      taken_r <= 1'b0;
      rdy_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      ic_r <= ic_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      strb_r <= strb_nxt;
      cnt_r <= cnt_nxt;
      mw_r <= mw_nxt;
      trap_r <= trap_nxt;
      op_pend_r <= op_pend_nxt;
      op_rd_r <= op_rd_nxt;
      op_addr_r <= op_addr_nxt;
      op_data_r <= op_data_nxt;
      rbyte_r <= rbyte_nxt;
      word_valid_r <= word_valid_nxt;
      taken_r <= taken_nxt;
      rdy_r <= rdy_nxt;
    end
  end

  // APB slave with one wait state so read data leaves a register
  assign apb_first = psel_i && penable_i && !pready_r;
  assign apb_done = psel_i && penable_i && pready_r;
  assign cmd_wr_go = apb_done && pwrite_i && (paddr_i == MST_OFF_CMD) && pwdata_i[MST_CMD_WR];
  assign cmd_rd_go = apb_done && pwrite_i && (paddr_i == MST_OFF_CMD) && pwdata_i[MST_CMD_RD];

  always_comb begin
    run_nxt = run_r;
    patch_byte_in_nxt = patch_byte_in_r;
    patch_store_address_nxt = patch_store_address_r;
    prdata_nxt = prdata_r;
    pready_nxt = apb_first;
    pslverr_nxt = 1'b0;
    mapped = 1'b1;
    case (paddr_i)
      MST_OFF_CTRL, MST_OFF_PDATA, MST_OFF_PADDR, MST_OFF_CMD: mapped = 1'b1;
      MST_OFF_STAT, MST_OFF_TRAP, MST_OFF_RBYTE, MST_OFF_CADDR: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
    if (apb_first) begin
      pslverr_nxt = !mapped;
      prdata_nxt = '0;
      if (!pwrite_i) begin
        case (paddr_i)
          MST_OFF_CTRL: prdata_nxt[MST_CTRL_RUN] = run_r;
          MST_OFF_PDATA: prdata_nxt[7:0] = patch_byte_in_r;
          MST_OFF_PADDR: prdata_nxt[MST_AW-1:0] = patch_store_address_r;
          MST_OFF_STAT: begin
            prdata_nxt[MST_STAT_CNT +: 3] = cnt_r;
            prdata_nxt[MST_STAT_PEND] = op_pend_r;
            prdata_nxt[MST_STAT_RUN] = run_r;
            prdata_nxt[MST_STAT_IDLE] = (state_r == ST_IDLE);
          end
          MST_OFF_TRAP: prdata_nxt[MST_NTRAP-1:0] = trap_r;
          MST_OFF_RBYTE: prdata_nxt[7:0] = rbyte_r;
          MST_OFF_CADDR: prdata_nxt[MST_AW-1:0] = addr_r;
          default: prdata_nxt = '0;
        endcase
      end
    end
    if (apb_done && pwrite_i) begin
      case (paddr_i)
        MST_OFF_CTRL: run_nxt = pwdata_i[MST_CTRL_RUN];
        MST_OFF_PDATA: patch_byte_in_nxt = pwdata_i[7:0];
        MST_OFF_PADDR: patch_store_address_nxt = pwdata_i[MST_AW-1:0];
        default: run_nxt = run_r;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      run_r <= MST_RUN_RST;
      patch_byte_in_r <= '0;
      patch_store_address_r <= '0;
      prdata_r <= '0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      run_r <= run_nxt;
      patch_byte_in_r <= patch_byte_in_nxt;
      patch_store_address_r <= patch_store_address_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata_o = prdata_r;
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;
  assign microword_o = mw_r;
  assign word_valid_o = word_valid_r;
  assign store_addr_o = addr_r;
  assign byte_write_strobes_o = strb_r;
  assign trap_taken_o = taken_r;
  assign loader_ready_o = rdy_r;

endmodule

/* File: tb/mst_core_checker.sv */
// Purpose: Port-level assertions for the microstore core.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound to the core from the bench top file.
`timescale 1ns/1ps
module mst_core_checker
  import mst_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire mst_load_s loader_i,
  input wire logic [MST_AW-1:0] store_addr_o,
  input wire logic [MST_BYTES-1:0] byte_write_strobes_o,
  input wire logic word_valid_o,
  input wire logic trap_taken_o,
  input wire logic loader_ready_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  property p_stb_lane;
    byte_write_strobes_o != '0 |-> $onehot(byte_write_strobes_o) ##1 byte_write_strobes_o == '0;
  endproperty
  a_stb_lane: assert property (p_stb_lane) else $error("byte strobe not a single one-cycle lane");

  property p_fetch_ro;
    trap_taken_o |-> (byte_write_strobes_o == '0) [*2];
  endproperty
  a_fetch_ro: assert property (p_fetch_ro) else $error("byte strobe during a fetch");

  property p_trap_word;
    trap_taken_o |-> ##2 word_valid_o;
  endproperty
  a_trap_word: assert property (p_trap_word) else $error("trap vector not fetched in time");

  property p_vec_ram;
    trap_taken_o |-> store_addr_o <= 14'h0017 && !(store_addr_o inside {[14'h000E:14'h0010]});
  endproperty
  a_vec_ram: assert property (p_vec_ram) else $error("trap vector outside the vector table");

  property p_word_gap;
    word_valid_o |=> !word_valid_o [*2];
  endproperty
  a_word_gap: assert property (p_word_gap) else $error("words closer than three cycles");

  property p_apb_wait;
    $rose(penable_i) && psel_i |-> !pready_o ##1 pready_o;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("bus answer not after one wait state");

  property p_ld_busy;
    loader_i.valid && loader_ready_o |=> !loader_ready_o;
  endproperty
  a_ld_busy: assert property (p_ld_busy) else $error("loader slot still free after a byte");

  property p_ld_write;
    loader_i.valid && loader_ready_o && !loader_i.loader_store_address[13] |-> ##[1:4] byte_write_strobes_o != '0;
  endproperty
  a_ld_write: assert property (p_ld_write) else $error("loader byte never written");
endmodule

/* File: tb/mst_loader_model.sv */
// Purpose: Diskette loader model that offers bytes to the store.
// Assumes: Called by the bench through its send task.
// Notes: Released lines show the inverse of the last byte, never a stale copy.
`timescale 1ns/1ps
module mst_loader_model
  import mst_pkg::*;
(
  input wire logic clk_i,
  input wire logic ready_i,
  output mst_load_s load_o
);
  initial load_o = '0;

  // Gap lets the bench be prompt or slow; ok drops if the slot never frees
  task automatic send(input logic [7:0] b, input logic [13:0] a, input int gap, output bit ok);
    int n;
    repeat (gap + 1) @(posedge clk_i);
    #1;
    for (n = 0; n < 64 && ready_i !== 1'b1; n++) begin
      @(posedge clk_i);
      #1;
    end
    ok = (ready_i === 1'b1);
    if (ok) begin
      @(posedge clk_i);
      load_o <= '{1'b1, b, a};
      @(posedge clk_i);
      load_o <= '{1'b0, ~b, ~a};
    end
  endtask
endmodule

/* File: tb/tb.sv */
// Purpose: Self-checking bench for the microstore core.
// Assumes: Loader model feeds bytes; traps and branches pulsed here.
// Notes: Fetch only ever runs inside the preloaded low 32 words.
`timescale 1ns/1ps
module tb
  import mst_pkg::*;
;
  logic clk_i, sys_rst_i, psel, penable, pwrite, pready, pslverr, sys_load, branch, wv, tt, ld_rdy;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [13:0] baddr, sa, last_sa;
  logic [47:0] mw;
  logic [6:0] stb, last_stb;
  mst_load_s ld;
  mst_trap_in_s trap;
  int failures, samples_checked;

  mst_core dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .loader_i(ld),
    .trap_i(trap), .sys_load_i(sys_load), .branch_i(branch), .branch_addr_i(baddr), .microword_o(mw),
    .word_valid_o(wv), .store_addr_o(sa), .byte_write_strobes_o(stb), .trap_taken_o(tt), .loader_ready_o(ld_rdy));
  mst_loader_model ld_u (.clk_i(clk_i), .ready_i(ld_rdy), .load_o(ld));

  initial begin
    clk_i = 0;
    forever #10 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (stb != '0) begin
      last_stb <= stb;
      last_sa <= sa;
    end
  end

  task automatic results();
    if (failures == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic quit();
    failures++;
    results();
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'h1;
    for (n = 0; n < 16; n++) begin
      @(posedge clk_i);
      if (pready === 1'b1) break;
    end
    if (n == 16) quit();
    // Error flag folded into bit 31; no register uses that bit
    q = prdata ^ {pslverr, 31'h0};
    if (pslverr === 1'b1 && prdata !== 32'h0) q = 32'hFFFFFFFF;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask

  // Ends once the slot is free and, with run low, the sequencer is parked
  task automatic stop();
    logic [31:0] q;
    int n;
    wr(MST_OFF_CTRL, 32'h0);
    for (n = 0; n < 16; n++) begin
      apb(1'b0, MST_OFF_STAT, 32'h0, q);
      if (q[MST_STAT_PEND] === 1'b0 && q[MST_STAT_IDLE] === 1'b1) break;
    end
    if (n == 16) quit();
  endtask

  task automatic wait_on(input bit trp, output logic [13:0] a, output logic [47:0] w);
    int n;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_i);
      if ((trp ? tt : wv) === 1'b1) break;
    end
    if (n == 40) quit();
    a = sa;
    w = mw;
  endtask

  task automatic pulse(input mst_trap_in_s t, input logic sl);
    @(posedge clk_i);
    trap <= t;
    sys_load <= sl;
    @(posedge clk_i);
    trap <= '0;
    sys_load <= 1'h0;
  endtask

  // Variant v moves the read-alignment case between 001 and 010
  function automatic logic [47:0] wd(input logic [13:0] a, input logic v);
    return {a, 2'h0, v ? 8'h10 : 8'h20, 8'hA5, 16'hC35A};
  endfunction

  function automatic mst_trap_in_s tin(input int i);
    mst_trap_in_s t;
    t = '0;
    case (i)
      1: t.init = '1;
      2: t.bad_physical_address_trap = '1;
      3: t.translate_reg0_trap = '1;
      4: t.translate_reg12_trap = '1;
      5: t.protection_trap = '1;
      6, 7: t.read_align = '1;
      8: t.write_align_trap = '1;
      9: t.halfword_align_trap = '1;
      10, 21: t.counter_overflow = '1;
      11: t.main_mem_parity_trap = '1;
      12: t.execute_target_trap = '1;
      14: t.external_event_trap = '1;
      15: t.software_breakpoint_trap = '1;
      16: t.clock_maint_trap = '1;
      17: t.clock_int = '1;
      18, 22: t.io_int = '1;
      19: t.page_break_trap = '1;
      20: t.entry_page_break_trap = '1;
      default: t.init = '0;
    endcase
    t.add_to_counter_op = (i == 10);
    t.subtract_from_counter_op = (i == 21);
    t.io_interrupt_allow = (i == 18);
    t.next_macro = (i == 12 || i > 13);
    return t;
  endfunction

  task automatic load_word(input logic [13:0] a, input logic [47:0] w, input logic [1:0] pf);
    logic [55:0] s;
    bit ok;
    s = {6'h00, {^w[47:24], ^w[23:0]} ^ pf, w};
    for (int i = 0; i < 7; i++) begin
      ld_u.send(s[8*i +: 8], a, i % 3, ok);
      if (!ok) quit();
      repeat (6) @(posedge clk_i);
      chk({last_sa, last_stb}, {a, 7'h01 << i});
    end
  endtask

  task automatic s_load(input logic v);
    logic [31:0] q;
    for (int a = 0; a < 32; a++) load_word(14'(a), wd(14'(a), v), 2'h0);
    apb(1'b0, MST_OFF_STAT, 32'h0, q);
    chk(q[2:0], 3'h0);
  endtask

  task automatic s_reset();
    logic [31:0] q;
    apb(1'b0, MST_OFF_TRAP, 32'h0, q);
    chk(q, 32'h1);
    apb(1'b0, MST_OFF_STAT, 32'h0, q);
    chk(q, 32'h20);
    apb(1'b0, 8'h20, 32'h0, q);
    chk(q, 32'h80000000);
  endtask

  task automatic s_patch();
    logic [31:0] q;
    wr(MST_OFF_PADDR, 32'h20);
    for (int i = 0; i < 14; i++) begin
      wr(MST_OFF_PDATA, 32'h30 + i % 7);
      wr(MST_OFF_CMD, i < 7 ? 32'h1 : 32'h2);
      stop();
      if (i < 7) chk({last_sa, last_stb}, {14'h20, 7'h01 << i});
      else begin
        apb(1'b0, MST_OFF_RBYTE, 32'h0, q);
        chk(q, 32'h30 + i - 7);
      end
    end
  endtask

  task automatic s_fetch();
    logic [13:0] a;
    logic [47:0] w;
    wr(MST_OFF_CTRL, 32'h1);
    wait_on(1'b1, a, w);
    chk(a, 14'h0);
    wait_on(1'b0, a, w);
    chk({a, w}, {14'h0, wd(14'h0, 1'b0)});
    wait_on(1'b0, a, w);
    chk({a, w}, {14'h1, wd(14'h1, 1'b0)});
  endtask

  task automatic s_traps();
    logic [31:0] q;
    logic [13:0] a;
    logic [47:0] w;
    int k;
    for (int i = 0; i < 23; i++) begin
      if (i == 13) continue;
      stop();
      if (i == 7) begin
        s_load(1'b1);
        wr(MST_OFF_CTRL, 32'h1);
        wait_on(1'b0, a, w);
        stop();
      end
      k = (i == 21) ? 10 : i;
      pulse(tin(i), i == 0);
      apb(1'b0, MST_OFF_TRAP, 32'h0, q);
      chk(q, i == 22 ? 32'h0 : 32'h1 << k);
      if (i == 22) continue;
      wr(MST_OFF_CTRL, 32'h1);
      wait_on(1'b1, a, w);
      chk(a, MST_TRAP_VEC[k]);
    end
  endtask

  task automatic s_prio();
    logic [13:0] a;
    logic [47:0] w;
    stop();
    pulse(tin(5) | tin(2), 1'b0);
    wr(MST_OFF_CTRL, 32'h1);
    wait_on(1'b1, a, w);
    chk(a, 14'h2);
    wait_on(1'b1, a, w);
    chk(a, 14'h5);
  endtask

  task automatic s_parity();
    logic [13:0] a;
    logic [47:0] w;
    stop();
    load_word(14'h1E, wd(14'h1E, 1'b1), 2'h1);
    baddr <= 14'h1E;
    branch <= 1'h1;
    wr(MST_OFF_CTRL, 32'h1);
    wait_on(1'b0, a, w);
    branch <= 1'h0;
    chk({a, w}, {14'h1E, wd(14'h1E, 1'b1)});
    wait_on(1'b1, a, w);
    chk(a, 14'hD);
    stop();
  endtask

  initial begin
    {psel, penable, pwrite, sys_load, branch, paddr, pwdata, baddr, trap} = '0;
    sys_rst_i = 1'h1;
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'h0;
    s_reset();
    s_load(1'b0);
    s_patch();
    s_fetch();
    s_traps();
    s_prio();
    s_parity();
    results();
  end
endmodule

bind mst_core mst_core_checker chk_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pready_o(pready_o), .loader_i(loader_i), .store_addr_o(store_addr_o),
  .byte_write_strobes_o(byte_write_strobes_o), .word_valid_o(word_valid_o), .trap_taken_o(trap_taken_o),
  .loader_ready_o(loader_ready_o));
